// ---- design/voice_status_pkg.sv ----
// shared constants and types for the voice recorder status register block
package voice_status_pkg;

  // command opcodes
  localparam logic [7:0] OPC_POWER_UP = 8'h01;
  localparam logic [7:0] OPC_STOP = 8'h02;
  localparam logic [7:0] OPC_RESET = 8'h03;
  localparam logic [7:0] OPC_FLAG_CLEAR = 8'h04;
  localparam logic [7:0] OPC_STATUS_FETCH = 8'h05;
  localparam logic [7:0] OPC_READ_MSG_START = 8'h06;
  localparam logic [7:0] OPC_POWER_DOWN = 8'h07;
  localparam logic [7:0] OPC_PLAYBACK = 8'h40;
  localparam logic [7:0] OPC_CAPTURE = 8'h41;
  localparam logic [7:0] OPC_ERASE = 8'h42;
  localparam logic [7:0] OPC_ROUTE_CFG_READ = 8'h44;
  localparam logic [7:0] OPC_ROUTE_CFG_WRITE = 8'h45;
  localparam logic [7:0] OPC_SKIP_AHEAD = 8'h48;
  localparam logic [7:0] OPC_QUEUED_OUTPUT = 8'h80;
  localparam logic [7:0] OPC_QUEUED_CAPTURE = 8'h81;
  localparam logic [7:0] OPC_QUEUED_ERASE = 8'h82;

  // primary status word bit positions
  localparam int SR0_REJECT_BIT = 0;
  localparam int SR0_POWERED_BIT = 2;
  localparam int SR0_DONE_BIT = 4;
  localparam int SR0_ROW_LSB = 5;

  // secondary status bit positions
  localparam int SS_READY_BIT = 0;
  localparam int SS_ERASE_BIT = 1;
  localparam int SS_PLAY_BIT = 2;
  localparam int SS_CAPTURE_BIT = 3;
  localparam int SS_SLOT4_BIT = 4;
  localparam int SS_SLOT1_BIT = 7;

  // response byte positions within a frame
  localparam logic [2:0] BYTE_SR0_LO = 3'h0;
  localparam logic [2:0] BYTE_SR0_HI = 3'h1;
  localparam logic [2:0] BYTE_THIRD = 3'h2;
  localparam logic [2:0] BYTE_FOURTH = 3'h3;

  localparam int ROUTE_CFG_W = 12;
  localparam int PTR_W = 11;
  localparam logic [11:0] ROUTE_CFG_RESET = 12'h000;
  localparam logic [10:0] MSG_START_RESET = 11'h000;
  localparam logic POWERED_RESET = 1'b0;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_CAPTURE = 2'b01,
    OP_PLAYBACK = 2'b11,
    OP_ERASE = 2'b10
  } op_state_t;

endpackage

// ---- design/link_sync.sv ----
// two-stage synchroniser for the serial link pins
`timescale 1ns/10ps
`default_nettype none
module link_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] IDLE = '0
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;

  // reset loads the pins' idle levels so release shows no false edge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stage1 <= IDLE;
      stage2 <= IDLE;
    end else begin
      stage1 <= din;
      stage2 <= stage1;
    end
  end

  assign dout = stage2;
endmodule
`default_nettype wire

// ---- design/voice_recorder_status_regs.sv ----
// serial command front end with secondary status, route config and message pointer
`timescale 1ns/10ps
`default_nettype none
module voice_recorder_status_regs (
  input wire logic clock,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic push_button_mode,
  input wire logic op_done,
  input wire logic [3:0] effect_set,
  input wire logic [3:0] effect_clear,
  input wire logic [10:0] current_row,
  input wire logic [10:0] next_message_row,
  output logic op_start,
  output logic [1:0] op_kind,
  output logic [10:0] op_start_row,
  output logic op_abort,
  output logic core_reset,
  output logic powered,
  output logic ready_level
);

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [2:0] pins_sync;
  logic sclk_s;
  logic ss_n_s;
  logic mosi_s;
  logic sclk_q;
  logic ss_n_q;

  link_sync #(.W(3), .IDLE(3'h6)) u_sync (
    .clock(clock),
    .resetn(resetn),
    .din({sclk, ss_n, mosi}),
    .dout(pins_sync)
  );

  assign sclk_s = pins_sync[2];
  assign ss_n_s = pins_sync[1];
  assign mosi_s = pins_sync[0];

  // reset to idle-high so release does not look like a frame start
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sclk_q <= 1'b1;
      ss_n_q <= 1'b1;
    end else begin
      sclk_q <= sclk_s;
      ss_n_q <= ss_n_s;
    end
  end

  wire frame_active = ~ss_n_s & ~ss_n_q;
  wire frame_begin = ~ss_n_s & ss_n_q;
  wire frame_end = ss_n_s & ~ss_n_q;
  wire sclk_rise = sclk_s & ~sclk_q & frame_active;
  wire sclk_fall = ~sclk_s & sclk_q & frame_active;

  ////////////////////////////////////////////////////////////////////////////////
  // receive shifter, least significant bit first

  logic [2:0] bit_cnt;
  logic [2:0] byte_cnt;
  logic [7:0] rx_shift;
  logic [7:0] cmd_byte;
  logic [7:0] data1;
  logic [7:0] data2;

  wire [7:0] rx_next = {mosi_s, rx_shift[7:1]};
  wire byte_done = sclk_rise & (bit_cnt == 3'h7);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bit_cnt <= 3'h0;
      byte_cnt <= 3'h0;
      rx_shift <= 8'h00;
    end else if (frame_begin) begin
      bit_cnt <= 3'h0;
      byte_cnt <= 3'h0;
    end else if (sclk_rise) begin
      rx_shift <= rx_next;
      bit_cnt <= bit_cnt + 3'h1;
      // saturate so long frames cannot wrap onto the command slot
      if (bit_cnt == 3'h7 && byte_cnt != 3'h7) begin
        byte_cnt <= byte_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmd_byte <= 8'h00;
      data1 <= 8'h00;
      data2 <= 8'h00;
    end else if (byte_done) begin
      if (byte_cnt == 3'h0) cmd_byte <= rx_next;
      if (byte_cnt == 3'h1) data1 <= rx_next;
      if (byte_cnt == 3'h2) data2 <= rx_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // command decode and acceptance

  voice_status_pkg::op_state_t op_state;
  logic set_mode;
  logic [7:0] set_cmd;
  logic queued;
  logic [10:0] queued_row;
  logic [3:0] effect_stored;
  logic cmd_reject;
  logic done_flag;
  logic [11:0] route_cfg;
  logic [10:0] msg_start;

  wire is_pu = cmd_byte == voice_status_pkg::OPC_POWER_UP;
  wire is_stop = cmd_byte == voice_status_pkg::OPC_STOP;
  wire is_reset = cmd_byte == voice_status_pkg::OPC_RESET;
  wire is_clear = cmd_byte == voice_status_pkg::OPC_FLAG_CLEAR;
  wire is_status = cmd_byte == voice_status_pkg::OPC_STATUS_FETCH;
  wire is_rd_ptr = cmd_byte == voice_status_pkg::OPC_READ_MSG_START;
  wire is_pd = cmd_byte == voice_status_pkg::OPC_POWER_DOWN;
  wire is_play = cmd_byte == voice_status_pkg::OPC_PLAYBACK;
  wire is_rec = cmd_byte == voice_status_pkg::OPC_CAPTURE;
  wire is_erase = cmd_byte == voice_status_pkg::OPC_ERASE;
  wire is_rd_cfg = cmd_byte == voice_status_pkg::OPC_ROUTE_CFG_READ;
  wire is_wr_cfg = cmd_byte == voice_status_pkg::OPC_ROUTE_CFG_WRITE;
  wire is_skip = cmd_byte == voice_status_pkg::OPC_SKIP_AHEAD;
  wire is_set_play = cmd_byte == voice_status_pkg::OPC_QUEUED_OUTPUT;
  wire is_queued_capture_cmd = cmd_byte == voice_status_pkg::OPC_QUEUED_CAPTURE;
  wire is_set_erase = cmd_byte == voice_status_pkg::OPC_QUEUED_ERASE;
  wire is_set = is_set_play | is_queued_capture_cmd | is_set_erase;
  wire is_start = is_play | is_rec | is_erase | is_set;
  wire is_known = is_pu | is_stop | is_reset | is_clear | is_status | is_rd_ptr | is_pd |
                  is_start | is_rd_cfg | is_wr_cfg | is_skip;

  wire op_busy = op_state != voice_status_pkg::OP_IDLE;
  wire cap_active = op_state == voice_status_pkg::OP_CAPTURE;
  wire play_active = op_state == voice_status_pkg::OP_PLAYBACK;
  wire erase_active = op_state == voice_status_pkg::OP_ERASE;
  wire exempt = is_reset | is_clear | is_status | is_pd;
  wire stop_ok = is_stop & (cap_active | play_active);
  wire same_set = set_mode & ~queued & (cmd_byte == set_cmd);
  wire accept = op_busy ? (exempt | stop_ok | same_set) : is_known;
  wire fire = frame_end & (byte_cnt != 3'h0);
  wire do_cmd = fire & accept;
  wire do_reject = fire & ~accept;

  wire start_new = do_cmd & ~op_busy & is_start;
  wire enqueue = do_cmd & op_busy & same_set;
  wire halt = do_cmd & (is_stop | is_reset | is_pd);
  wire done_now = op_done & op_busy & ~halt;
  wire [10:0] cmd_row = {data2[2:0], data1};

  voice_status_pkg::op_state_t start_state;
  always_comb begin
    case (cmd_byte)
      voice_status_pkg::OPC_CAPTURE: start_state = voice_status_pkg::OP_CAPTURE;
      voice_status_pkg::OPC_QUEUED_CAPTURE: start_state = voice_status_pkg::OP_CAPTURE;
      voice_status_pkg::OPC_PLAYBACK: start_state = voice_status_pkg::OP_PLAYBACK;
      voice_status_pkg::OPC_QUEUED_OUTPUT: start_state = voice_status_pkg::OP_PLAYBACK;
      voice_status_pkg::OPC_ERASE: start_state = voice_status_pkg::OP_ERASE;
      voice_status_pkg::OPC_QUEUED_ERASE: start_state = voice_status_pkg::OP_ERASE;
      default: start_state = voice_status_pkg::OP_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // operation state and core handshake

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      op_state <= voice_status_pkg::OP_IDLE;
      set_mode <= 1'b0;
      set_cmd <= 8'h00;
      queued <= 1'b0;
      queued_row <= 11'h000;
    end else if (halt) begin
      op_state <= voice_status_pkg::OP_IDLE;
      set_mode <= 1'b0;
      queued <= 1'b0;
    end else if (start_new) begin
      op_state <= start_state;
      set_mode <= is_set;
      set_cmd <= cmd_byte;
    end else if (enqueue) begin
      queued <= 1'b1;
      queued_row <= cmd_row;
    end else if (done_now) begin
      // a queued set command follows on directly, same kind
      if (queued) begin
        queued <= 1'b0;
      end else begin
        op_state <= voice_status_pkg::OP_IDLE;
        set_mode <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      op_start <= 1'b0;
      op_kind <= 2'b00;
      op_start_row <= 11'h000;
      op_abort <= 1'b0;
      core_reset <= 1'b0;
    end else begin
      op_start <= start_new | (done_now & queued);
      op_abort <= halt & op_busy;
      core_reset <= do_cmd & is_reset;
      if (start_new) begin
        op_kind <= start_state;
        op_start_row <= is_set ? cmd_row : current_row;
      end else if (done_now & queued) begin
        op_start_row <= queued_row;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // flags, route configuration and pointer

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmd_reject <= 1'b0;
      done_flag <= 1'b0;
      effect_stored <= 4'h0;
      powered <= voice_status_pkg::POWERED_RESET;
    end else begin
      // each frame of at least one whole byte rewrites the flag: set when ignored, clear when taken
      if (fire) cmd_reject <= do_reject;
      // completion beats a clear arriving in the same cycle
      if (done_now) begin
        done_flag <= 1'b1;
      end else if (do_cmd & is_clear) begin
        done_flag <= 1'b0;
      end
      effect_stored <= (effect_stored & ~effect_clear) | effect_set;
      if (do_cmd & is_pu) powered <= 1'b1;
      if (do_cmd & is_pd) powered <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      route_cfg <= voice_status_pkg::ROUTE_CFG_RESET;
    end else if (do_cmd & is_reset) begin
      route_cfg <= voice_status_pkg::ROUTE_CFG_RESET;
    end else if (do_cmd & is_wr_cfg) begin
      route_cfg <= {data2[3:0], data1};
    end
  end

  // only skip-ahead, reset and capture starts touch the pointer
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      msg_start <= voice_status_pkg::MSG_START_RESET;
    end else if (do_cmd & is_reset) begin
      msg_start <= voice_status_pkg::MSG_START_RESET;
    end else if (do_cmd & is_skip) begin
      msg_start <= next_message_row;
    end else if (start_new & (start_state == voice_status_pkg::OP_CAPTURE)) begin
      msg_start <= is_set ? cmd_row : current_row;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // status words and response shifter

  // same ready rule in both modes; set ops report an empty one-deep buffer
  wire ready = ~op_busy | (set_mode & ~queued);
  assign ready_level = ready;

  wire [15:0] sr0 = {current_row, done_flag, 1'b0, powered, 1'b0, cmd_reject};
  wire [7:0] sec_status = {effect_stored[0], effect_stored[1], effect_stored[2],
                           effect_stored[3], cap_active, play_active,
                           erase_active, ready};

  logic [15:0] read_word;
  always_comb begin
    read_word = 16'h0000;
    if (is_status) read_word = {8'h00, sec_status};
    if (is_rd_ptr) read_word = {5'h00, msg_start};
    if (is_rd_cfg) read_word = {4'h0, route_cfg};
  end

  logic [7:0] resp_byte;
  always_comb begin
    case (byte_cnt)
      voice_status_pkg::BYTE_SR0_LO: resp_byte = sr0[7:0];
      voice_status_pkg::BYTE_SR0_HI: resp_byte = sr0[15:8];
      voice_status_pkg::BYTE_THIRD: resp_byte = read_word[7:0];
      voice_status_pkg::BYTE_FOURTH: resp_byte = read_word[15:8];
      default: resp_byte = 8'h00;
    endcase
  end

  // status is live, not frozen at frame start: fields may move mid-frame
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      miso <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      miso_oe <= ~ss_n_s;
      if (frame_begin) begin
        miso <= sr0[voice_status_pkg::SR0_REJECT_BIT];
      end else if (sclk_fall) begin
        miso <= resp_byte[bit_cnt];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  sequence busy_plain_s;
    op_busy & ~set_mode;
  endsequence

  sequence refused_frame_s;
    fire & op_busy & ~exempt & ~stop_ok & ~same_set;
  endsequence

  AST_SLOT1_SET: assert property (@(posedge clock) disable iff (!resetn)
    effect_set[0] |=> sec_status[voice_status_pkg::SS_SLOT1_BIT])
    else $error("slot one flag not set after record");

  AST_SLOT4_CLEAR: assert property (@(posedge clock) disable iff (!resetn)
    effect_clear[3] & ~effect_set[3] |=> ~sec_status[voice_status_pkg::SS_SLOT4_BIT])
    else $error("slot four flag not cleared after erase");

  AST_CAPTURE_BIT: assert property (@(posedge clock) disable iff (!resetn)
    start_new & is_rec |=> sec_status[voice_status_pkg::SS_CAPTURE_BIT] &
      op_kind == voice_status_pkg::OP_CAPTURE)
    else $error("capture bit missing after record start");

  AST_PLAY_BIT: assert property (@(posedge clock) disable iff (!resetn)
    start_new & is_play |=> sec_status[voice_status_pkg::SS_PLAY_BIT] ##1 op_busy)
    else $error("playback bit missing after play start");

  AST_ERASE_BIT: assert property (@(posedge clock) disable iff (!resetn)
    start_new & is_erase |=> sec_status[voice_status_pkg::SS_ERASE_BIT])
    else $error("erase bit missing after erase start");

  AST_ONE_ACTIVE: assert property (@(posedge clock) disable iff (!resetn)
    $onehot0(sec_status[voice_status_pkg::SS_CAPTURE_BIT:voice_status_pkg::SS_ERASE_BIT]))
    else $error("more than one activity bit set");

  AST_BUSY_NOT_READY: assert property (@(posedge clock) disable iff (!resetn)
    busy_plain_s |-> ~sec_status[voice_status_pkg::SS_READY_BIT])
    else $error("ready high during plain operation");

  AST_IDLE_READY: assert property (@(posedge clock) disable iff (!resetn)
    $fell(op_busy) |-> ready_level)
    else $error("ready low after operation end");

  AST_REJECT_SET: assert property (@(posedge clock) disable iff (!resetn)
    refused_frame_s |=> cmd_reject & $stable(route_cfg) & $stable(msg_start))
    else $error("refused command had effect or no reject flag");

  AST_STOP_TAKEN: assert property (@(posedge clock) disable iff (!resetn)
    fire & stop_ok |=> ~op_busy & ~cmd_reject ##0 op_abort)
    else $error("stop not honoured during capture or playback");

  AST_ROUTE_WRITE: assert property (@(posedge clock) disable iff (!resetn)
    do_cmd & is_wr_cfg & ~is_reset |=> route_cfg == $past({data2[3:0], data1}))
    else $error("route config not loaded");

  AST_PTR_HOLD: assert property (@(posedge clock) disable iff (!resetn)
    ~(do_cmd & (is_reset | is_skip)) &
    ~(start_new & start_state == voice_status_pkg::OP_CAPTURE)
    |=> $stable(msg_start))
    else $error("message pointer moved without cause");

endmodule
`default_nettype wire

// ---- dv/spi_host_model.sv ----
// host side model: serial master, idle-high clock, lsb first
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  output logic sclk,
  output logic ss_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sclk = 1'b1;
    ss_n = 1'b1;
    mosi = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // clock stands high outside frames; mosi flips once released so no stale bit
  // caller starts just after a clock edge; every step is whole clock periods
  task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
    rx = 32'h0000_0000;
    ss_n = 1'b0;
    #80;
    for (int i = 0; i < nbits; i++) begin
      sclk = 1'b0;
      mosi = tx[i];
      #80;
      sclk = 1'b1;
      rx[i] = miso;
      #80;
    end
    ss_n = 1'b1;
    mosi = ~mosi;
    #160;
  endtask
endmodule
`default_nettype wire

// ---- dv/voice_recorder_status_regs_test.sv ----
// self-checking bench for the status, route config and pointer block
`timescale 1ns/10ps
`default_nettype none
module voice_recorder_status_regs_test;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic push_button_mode = 1'b0;
  logic op_done = 1'b0;
  logic [3:0] effect_set = 4'h0;
  logic [3:0] effect_clear = 4'h0;
  logic [10:0] current_row = 11'h000;
  logic [10:0] next_message_row = 11'h000;
  wire logic sclk;
  wire logic ss_n;
  wire logic mosi;
  wire logic miso_line;
  logic miso;
  logic miso_oe;
  logic miso_last = 1'b0;
  logic op_start;
  logic [1:0] op_kind;
  logic [10:0] op_start_row;
  logic op_abort;
  logic core_reset;
  logic powered;
  logic ready_level;
  logic [31:0] rx;
  logic [1:0] last_kind;
  logic [10:0] last_row;
  int n_start = 0;
  int n_abort = 0;
  int n_creset = 0;
  int n_errors = 0;
  int compares = 0;

  initial begin
    forever #2.5 clock = ~clock;
  end

  voice_recorder_status_regs uut (
    .clock(clock), .resetn(resetn), .sclk(sclk), .ss_n(ss_n), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .push_button_mode(push_button_mode),
    .op_done(op_done), .effect_set(effect_set), .effect_clear(effect_clear),
    .current_row(current_row), .next_message_row(next_message_row),
    .op_start(op_start), .op_kind(op_kind), .op_start_row(op_start_row),
    .op_abort(op_abort), .core_reset(core_reset), .powered(powered),
    .ready_level(ready_level)
  );

  spi_host_model host (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso_line));

  // released line shows the inverse of its last driven level
  always @(posedge clock) begin
    if (miso_oe === 1'b1) miso_last <= miso;
  end
  assign miso_line = (miso_oe === 1'b1) ? miso : ~miso_last;

  always @(posedge clock) begin
    if (op_start === 1'b1) begin
      n_start++;
      last_kind = op_kind;
      last_row = op_start_row;
    end
    if (op_abort === 1'b1) n_abort++;
    if (core_reset === 1'b1) n_creset++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task test_done();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // every frame carries four bytes; response is captured in rx
  task f(input logic [7:0] op, input logic [7:0] d1, input logic [7:0] d2);
    @(posedge clock);
    #1 host.xfer({8'h00, d2, d1, op}, 32, rx);
  endtask

  task st(input logic [7:0] exp, input string what);
    f(8'h05, 8'h00, 8'h00);
    check(what, {8'h00, rx[23:16]}, {8'h00, exp});
  endtask

  task done_pulse();
    @(posedge clock);
    #1 op_done = 1'b1;
    @(posedge clock);
    #1 op_done = 1'b0;
    // let the start pulse reach the bench monitor
    @(posedge clock);
    #1;
  endtask

  task fx(input logic [3:0] s, input logic [3:0] c);
    @(posedge clock);
    #1 effect_set = s;
    effect_clear = c;
    @(posedge clock);
    #1 effect_set = 4'h0;
    effect_clear = 4'h0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clock);
    #1 resetn = 1'b1;
    repeat (6) @(posedge clock);
    st(8'h01, "ready serial");
    check("reject idle", {15'h0000, rx[0]}, 16'h0000);
    push_button_mode = 1'b1;
    st(8'h01, "ready button");
    f(8'h01, 8'h00, 8'h00);
    check("powered", {15'h0000, powered}, 16'h0001);
    f(8'h44, 8'h00, 8'h00);
    check("cfg reset", {4'h0, rx[27:24], rx[23:16]}, 16'h0000);
    f(8'h45, 8'ha5, 8'hf3);
    f(8'h44, 8'h00, 8'h00);
    check("cfg", {4'h0, rx[27:24], rx[23:16]}, 16'h03a5);
    fx(4'h5, 4'h0);
    st(8'ha1, "effects set");
    // slot four cleared while never set: flag must stay low
    fx(4'h0, 4'h9);
    st(8'h21, "effects clear");
    current_row = 11'h123;
    next_message_row = 11'h2ab;
    f(8'h06, 8'h00, 8'h00);
    check("ptr reset", {5'h00, rx[26:24], rx[23:16]}, 16'h0000);
    f(8'h48, 8'h00, 8'h00);
    f(8'h06, 8'h00, 8'h00);
    check("ptr skip", {5'h00, rx[26:24], rx[23:16]}, 16'h02ab);
    // playback: refused capture, then stop
    f(8'h40, 8'h00, 8'h00);
    check("kind play", {14'h0000, last_kind}, 16'h0003);
    st(8'h24, "playing");
    check("ready pin", {15'h0000, ready_level}, 16'h0000);
    f(8'h41, 8'h00, 8'h00);
    f(8'h06, 8'h00, 8'h00);
    check("reject", {15'h0000, rx[0]}, 16'h0001);
    check("ptr kept", {5'h00, rx[26:24], rx[23:16]}, 16'h02ab);
    check("starts", n_start[15:0], 16'h0001);
    f(8'h02, 8'h00, 8'h00);
    check("abort", n_abort[15:0], 16'h0001);
    st(8'h21, "stopped");
    check("reject clr", {15'h0000, rx[0]}, 16'h0000);
    // capture: refused erase, ends on done
    f(8'h41, 8'h00, 8'h00);
    check("kind cap", {14'h0000, last_kind}, 16'h0001);
    st(8'h28, "capturing");
    f(8'h42, 8'h00, 8'h00);
    f(8'h06, 8'h00, 8'h00);
    check("reject", {15'h0000, rx[0]}, 16'h0001);
    check("ptr cap", {5'h00, rx[26:24], rx[23:16]}, 16'h0123);
    done_pulse();
    st(8'h21, "cap done");
    // erase refuses stop
    f(8'h42, 8'h00, 8'h00);
    st(8'h22, "erasing");
    f(8'h02, 8'h00, 8'h00);
    st(8'h22, "stop refused");
    check("reject", {15'h0000, rx[0]}, 16'h0001);
    check("no abort", n_abort[15:0], 16'h0001);
    done_pulse();
    st(8'h21, "erase done");
    // queued capture: one-deep buffer
    f(8'h81, 8'h45, 8'h01);
    check("set row", {5'h00, last_row}, 16'h0145);
    st(8'h29, "buffer empty");
    f(8'h81, 8'h10, 8'h00);
    st(8'h28, "buffer full");
    f(8'h40, 8'h00, 8'h00);
    st(8'h28, "play refused");
    check("reject", {15'h0000, rx[0]}, 16'h0001);
    done_pulse();
    check("queued row", {5'h00, last_row}, 16'h0010);
    f(8'h02, 8'h00, 8'h00);
    check("abort set", n_abort[15:0], 16'h0002);
    st(8'h21, "set stopped");
    check("ready pin", {15'h0000, ready_level}, 16'h0001);
    // reset command, unknown opcode, power-down
    f(8'h03, 8'h00, 8'h00);
    check("core reset", n_creset[15:0], 16'h0001);
    f(8'h44, 8'h00, 8'h00);
    check("cfg cleared", {4'h0, rx[27:24], rx[23:16]}, 16'h0000);
    f(8'h06, 8'h00, 8'h00);
    check("ptr cleared", {5'h00, rx[26:24], rx[23:16]}, 16'h0000);
    f(8'h33, 8'h00, 8'h00);
    st(8'h21, "unknown");
    check("reject", {15'h0000, rx[0]}, 16'h0001);
    f(8'h07, 8'h00, 8'h00);
    check("powered off", {15'h0000, powered}, 16'h0000);
    test_done();
  end

  // roughly forty frames of about 5.4 us each
  initial begin
    #400000;
    n_errors++;
    test_done();
  end
endmodule
`default_nettype wire
